// *** hw/nfc_host.sv ***
// Host-side sequencer that drives the NAND flash command, address and data pins
// ------------------------------------------------------------
// Summary of operation
// ------------------------------------------------------------
// Summary of operation
// [R1] Device latches command byte on rising write strobe with command strobe high.
// [R2] Device latches address byte on rising write strobe with address strobe high.
// [R3] Chip select high while ready puts the device in standby.
// [R4] While busy the device ignores chip select.
// [R5] Each output strobe fall presents next byte and advances column.
// [R6] Protect low blocks program and erase.
// [R7] Ready/busy is open drain, low during operations, high when done.
// [R8] Page is 2176 bytes, 2048 main plus 128 spare; 64 pages per block.
// [R9] Address is five bytes; spare upper bits are sent low.
// [R10] Row bits 0-5 select page, bits 6-16 select block.
// [R11] Data input: strobes low, chip select low, output strobe and protect high.
// [R12] Device drives the port only while output strobe is low.
// [R13] Host keeps strobes idle while busy, except status and reset.
// [R14] Device accepts only 70h, 71h and FFh while busy.
// [R15] Read commands: 00h-30h, 05h-E0h, 31h, 3Fh.
// [R16] Program 80h-10h; 85h changes input column.
// [R17] Cache program 80h-15h; multi-page 80h-11h then 81h-15h or 81h-10h.
// [R18] Page copy 00h-3Ah then 8Ch-15h or 8Ch-10h.
// [R19] Erase 60h-D0h, ID 90h, status 70h and 71h, reset FFh.
// [R20] After 81h-15h ending, poll status then issue FFh before anything else.
// [R21] After power-on the first read needs only address and 30h.
// [R22] 30h starts the array transfer; device busy, then ready.
// [R23] Host waits for ready before commands other than status or reset.
// [R24] Strobes are ignored with chip select high.
`timescale 1ns/1ps
`default_nettype none
module nfc_host
    import nfc_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Request port
    input  wire logic       req_valid,
    input  wire nfc_req_t   req,
    output logic            req_ready,
    output nfc_rsp_t        rsp,
    // Program and erase permission
    input  wire logic       allow_program,
    // Flash pins
    output nfc_pins_t       pins,
    input  wire logic [7:0] io_in,
    input  wire logic       ready_busy_n
);
    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_SETUP    = 3'b001,
        S_WSTROBE  = 3'b010,
        S_RSTROBE  = 3'b011,
        S_WAIT_WB  = 3'b100,
        S_WAIT_RDY = 3'b101
    } nfc_state_t;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_core_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync[1];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    nfc_state_t       state, next_state;
    nfc_req_t         cur, next_cur;
    logic [2:0]       idx, next_idx;
    logic             last_wr, next_last_wr;
    logic             stat_mode, next_stat_mode;
    logic             need_reset, next_need_reset;
    logic             busy_acc, next_busy_acc;
    logic [7:0]       prev_cmd, next_prev_cmd;
    nfc_pins_t        next_pins;
    nfc_rsp_t         next_rsp;
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic             tmr_done;
    logic             allowed;
    logic             more_bytes;
    logic [TMR_W-1:0] gap;

    nfc_timer u_timer (
        .core_clk   (core_clk),
        .rst_core_n (rst_core_n),
        .load       (tmr_load),
        .value      (tmr_val),
        .expired    (tmr_done)
    );

    always_comb begin
        next_state      = state;
        next_cur        = cur;
        next_idx        = idx;
        next_last_wr    = last_wr;
        next_stat_mode  = stat_mode;
        next_need_reset = need_reset;
        next_busy_acc   = busy_acc;
        next_prev_cmd   = prev_cmd;
        next_pins       = pins;
        next_rsp        = '0;
        tmr_load        = 1'b0;
        tmr_val         = T_WH_CYC;
        allowed         = 1'b0;
        more_bytes      = 1'b0;
        gap             = T_WH_CYC;
        next_pins.protect_n = allow_program;                                   // R6
        unique case (state)
            S_IDLE: begin
                next_pins.command_latch_strobe = 1'b0;
                next_pins.address_latch_strobe = 1'b0;
                next_pins.write_strobe_n       = 1'b1;
                next_pins.output_strobe_n      = 1'b1;
                next_pins.io_oe                = 1'b0;
                next_pins.chip_select_n        = 1'b1;                         // R3 R4
                if (req_valid && req_ready) begin
                    allowed = ((req.kind == K_CMD) && nfc_busy_ok(req.data))   // R13 R14
                           || (ready_busy_n && !need_reset)                    // R23 R20
                           || ((req.kind == K_READ) && stat_mode);
                    if (req.kind == K_WRITE && !allow_program) begin
                        allowed = 1'b0;                                        // R11
                    end
                    if (!allowed) begin
                        next_rsp.refused = 1'b1;
                    end else begin
                        if (req.kind == K_READ) begin
                            gap = last_wr ? T_WHR_CYC : T_REH_CYC;
                        end else begin
                            gap = last_wr ? T_WH_CYC : T_RHW_CYC;
                        end
                        if (pins.chip_select_n && gap < T_CS_CYC) begin
                            gap = T_CS_CYC;
                        end
                        tmr_load                       = 1'b1;
                        tmr_val                        = gap;
                        next_cur                       = req;
                        next_idx                       = 3'h0;
                        next_busy_acc                  = !ready_busy_n;
                        next_pins.chip_select_n        = 1'b0;                 // R24
                        next_pins.command_latch_strobe = (req.kind == K_CMD);  // R1
                        next_pins.address_latch_strobe = (req.kind == K_ADDR)
                                                      || (req.kind == K_COL);  // R2
                        next_pins.io_oe                = (req.kind != K_READ); // R12
                        next_pins.io_out               = (req.kind == K_ADDR || req.kind == K_COL)
                                                       ? nfc_addr_byte(req, 3'h0) : req.data;
                        next_state                     = S_SETUP;
                    end
                end
            end
            S_SETUP: begin
                // Address byte moves a cycle after the strobe rise, for hold
                if (cur.kind == K_ADDR || cur.kind == K_COL) begin
                    next_pins.io_out = nfc_addr_byte(cur, idx);                // R9 R10
                end
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    if (cur.kind == K_READ) begin
                        tmr_val                   = T_REA_CYC;
                        next_pins.output_strobe_n = 1'b0;                      // R5
                        next_state                = S_RSTROBE;
                    end else begin
                        tmr_val                  = T_WP_CYC;
                        next_pins.write_strobe_n = 1'b0;
                        next_state               = S_WSTROBE;
                    end
                end
            end
            S_WSTROBE: begin
                if (tmr_done) begin
                    next_pins.write_strobe_n = 1'b1;
                    next_last_wr             = 1'b1;
                    more_bytes = ((cur.kind == K_ADDR) && (idx != ADDR_LAST_IDX))
                              || ((cur.kind == K_COL) && (idx != COL_LAST_IDX));
                    if (more_bytes) begin
                        next_idx         = idx + 3'h1;
                        tmr_load         = 1'b1;
                        tmr_val          = T_WH_CYC;
                        next_state       = S_SETUP;
                    end else if (cur.kind == K_CMD) begin
                        next_prev_cmd  = cur.data;
                        next_stat_mode = (cur.data == CMD_STATUS) || (cur.data == CMD_STATUS_MP);
                        if (cur.data == CMD_CACHE_PROG && prev_cmd == CMD_MULTI_NEXT) begin
                            next_need_reset = 1'b1;                            // R20
                        end else if (cur.data == CMD_RESET) begin
                            next_need_reset = 1'b0;                            // R20
                        end
                        if (nfc_starts_busy(cur.data)) begin
                            tmr_load   = 1'b1;                                 // R22
                            tmr_val    = T_WB_CYC;
                            next_state = S_WAIT_WB;
                        end else begin
                            next_rsp.done = 1'b1;
                            next_state    = S_IDLE;
                        end
                    end else begin
                        next_rsp.done = 1'b1;
                        next_state    = S_IDLE;
                    end
                end
            end
            S_RSTROBE: begin
                if (tmr_done) begin
                    next_pins.output_strobe_n = 1'b1;
                    next_last_wr              = 1'b0;
                    next_rsp.done             = 1'b1;
                    next_rsp.rd_valid         = 1'b1;
                    next_rsp.rd_data          = io_in;                         // R5
                    next_state                = S_IDLE;
                end
            end
            S_WAIT_WB: begin
                if (tmr_done) begin
                    next_state = S_WAIT_RDY;
                end
            end
            S_WAIT_RDY: begin
                if (ready_busy_n) begin                                        // R7 R23
                    next_rsp.done = 1'b1;
                    next_state    = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state      <= S_IDLE;
            cur        <= '0;
            idx        <= 3'h0;
            last_wr    <= 1'b0;
            stat_mode  <= 1'b0;
            need_reset <= 1'b0;
            busy_acc   <= 1'b0;
            prev_cmd   <= CMD_READ_SETUP;                                      // R21
            pins       <= '{chip_select_n: 1'b1, command_latch_strobe: 1'b0,
                            address_latch_strobe: 1'b0, write_strobe_n: 1'b1,
                            output_strobe_n: 1'b1, protect_n: 1'b0,
                            io_out: 8'h00, io_oe: 1'b0};
            rsp        <= '0;
            req_ready  <= 1'b0;
        end else begin
            state      <= next_state;
            cur        <= next_cur;
            idx        <= next_idx;
            last_wr    <= next_last_wr;
            stat_mode  <= next_stat_mode;
            need_reset <= next_need_reset;
            busy_acc   <= next_busy_acc;
            prev_cmd   <= next_prev_cmd;
            pins       <= next_pins;
            rsp        <= next_rsp;
            req_ready  <= (next_state == S_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_core_n);

    property p_addr_upper_low;
        (pins.address_latch_strobe && !pins.write_strobe_n) |->
            ((idx == 3'h1) -> (pins.io_out[7:4] == 4'h0)) &&
            ((idx == ADDR_LAST_IDX) -> (pins.io_out[7:1] == 7'h00));
    endproperty
    a_addr_upper_low: assert property (p_addr_upper_low) else $error("address pad bits not low"); // R9

    property p_data_in_levels;
        (!pins.write_strobe_n && !pins.command_latch_strobe && !pins.address_latch_strobe)
            |-> !pins.chip_select_n && pins.output_strobe_n && pins.protect_n && pins.io_oe;
    endproperty
    a_data_in_levels: assert property (p_data_in_levels) else $error("bad data input levels"); // R11

    property p_we_width;
        $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*2] ##1 pins.write_strobe_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong"); // R11

    property p_re_excl;
        !pins.output_strobe_n |-> pins.write_strobe_n && !pins.io_oe && !pins.chip_select_n;
    endproperty
    a_re_excl: assert property (p_re_excl) else $error("read strobe overlaps write drive"); // R11

    property p_re_sample;
        $fell(pins.output_strobe_n) |->
            !pins.output_strobe_n [*3] ##1 (pins.output_strobe_n && rsp.rd_valid);
    endproperty
    a_re_sample: assert property (p_re_sample) else $error("read sample timing wrong"); // R5

    property p_busy_quiet;
        ($fell(pins.write_strobe_n) && busy_acc) |->
            pins.command_latch_strobe && nfc_busy_ok(pins.io_out);
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("strobe while busy"); // R13

    property p_reset_after_cache;
        ($fell(pins.write_strobe_n) && need_reset) |->
            pins.command_latch_strobe && nfc_busy_ok(pins.io_out);
    endproperty
    a_reset_after_cache: assert property (p_reset_after_cache) else $error("no reset after 81h-15h"); // R20

    property p_wait_ready;
        (state == S_WAIT_RDY && ready_busy_n) |=> (state == S_IDLE) && rsp.done && req_ready;
    endproperty
    a_wait_ready: assert property (p_wait_ready) else $error("ready not honoured"); // R23

    property p_wb_hold;
        $rose(state == S_WAIT_WB) |-> (state == S_WAIT_WB) [*8];
    endproperty
    a_wb_hold: assert property (p_wb_hold) else $error("busy wait too short"); // R22

    c_cmd_busy: cover property (state == S_WAIT_RDY ##1 state == S_IDLE);
    c_read:     cover property (rsp.rd_valid);
    c_addr5:    cover property (pins.address_latch_strobe && idx == ADDR_LAST_IDX);
    c_refused:  cover property (rsp.refused);
endmodule
`default_nettype wire

// *** hw/nfc_pkg.sv ***
// Package of constants, types and helpers for the NAND flash host controller
package nfc_pkg;

    // ------------------------------------------------------------
    // Clock and pin timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_WP_NS       = 12;
    localparam int T_WH_NS       = 10;
    localparam int T_CS_NS       = 20;
    localparam int T_WHR_NS      = 60;
    localparam int T_RHW_NS      = 30;
    localparam int T_REA_NS      = 20;
    localparam int T_REH_NS      = 10;
    localparam int T_WB_NS       = 100;

    localparam int TMR_W = 4;
    localparam logic [TMR_W-1:0] T_WP_CYC  = TMR_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] T_WH_CYC  = TMR_W'((T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] T_CS_CYC  = TMR_W'((T_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] T_WHR_CYC = TMR_W'((T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] T_RHW_CYC = TMR_W'((T_RHW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] T_REA_CYC = TMR_W'((T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] T_REH_CYC = TMR_W'((T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] T_WB_CYC  = TMR_W'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Geometry and address layout
    // ------------------------------------------------------------
    localparam int PAGE_BYTES      = 2176; // R8
    localparam int MAIN_BYTES      = 2048;
    localparam int SPARE_BYTES     = 128;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int COL_W           = 12;
    localparam int PAGE_W          = 6;
    localparam int BLOCK_W         = 11;
    localparam int ROW_W           = PAGE_W + BLOCK_W;
    localparam logic [2:0] ADDR_LAST_IDX = 3'h4;
    localparam logic [2:0] COL_LAST_IDX  = 3'h1;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
    localparam logic [7:0] CMD_READ_START  = 8'h30;
    localparam logic [7:0] CMD_COL_OUT     = 8'h05;
    localparam logic [7:0] CMD_COL_OUT_END = 8'he0;
    localparam logic [7:0] CMD_CACHE_RD    = 8'h31;
    localparam logic [7:0] CMD_CACHE_LAST  = 8'h3f;
    localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
    localparam logic [7:0] CMD_PROG        = 8'h10;
    localparam logic [7:0] CMD_COL_IN      = 8'h85;
    localparam logic [7:0] CMD_CACHE_PROG  = 8'h15;
    localparam logic [7:0] CMD_MULTI_FIRST = 8'h11;
    localparam logic [7:0] CMD_MULTI_NEXT  = 8'h81;
    localparam logic [7:0] CMD_COPY_RD     = 8'h3a;
    localparam logic [7:0] CMD_COPY_PROG   = 8'h8c;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE       = 8'hd0;
    localparam logic [7:0] CMD_ID          = 8'h90;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] CMD_STATUS_MP   = 8'h71;
    localparam logic [7:0] CMD_RESET       = 8'hff;
    localparam int         STATUS_BUSY_BIT = 6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        K_CMD   = 3'b000,
        K_ADDR  = 3'b001,
        K_COL   = 3'b010,
        K_WRITE = 3'b011,
        K_READ  = 3'b100
    } nfc_kind_t;

    typedef struct packed {
        nfc_kind_t          kind;
        logic [7:0]         data;
        logic [COL_W-1:0]   column_bits;
        logic [BLOCK_W-1:0] block;
        logic [PAGE_W-1:0]  page;
    } nfc_req_t;

    typedef struct packed {
        logic       done;
        logic       refused;
        logic       rd_valid;
        logic [7:0] rd_data;
    } nfc_rsp_t;

    typedef struct packed {
        logic       chip_select_n;
        logic       command_latch_strobe;
        logic       address_latch_strobe;
        logic       write_strobe_n;
        logic       output_strobe_n;
        logic       protect_n;
        logic [7:0] io_out;
        logic       io_oe;
    } nfc_pins_t;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic nfc_busy_ok(input logic [7:0] c);
        return (c == CMD_STATUS) || (c == CMD_STATUS_MP) || (c == CMD_RESET); // R14
    endfunction

    function automatic logic nfc_starts_busy(input logic [7:0] c); // R15 R16 R17 R18 R19
        return (c == CMD_READ_START) || (c == CMD_CACHE_RD) || (c == CMD_CACHE_LAST) ||
               (c == CMD_COPY_RD) || (c == CMD_PROG) || (c == CMD_CACHE_PROG) ||
               (c == CMD_MULTI_FIRST) || (c == CMD_ERASE) || (c == CMD_RESET);
    endfunction

    function automatic logic [7:0] nfc_addr_byte(input nfc_req_t r, input logic [2:0] idx);
        logic [ROW_W-1:0] row_bits;
        row_bits = {r.block, r.page};
        case (idx)
            3'h0:    return r.column_bits[7:0];
            3'h1:    return {4'h0, r.column_bits[11:8]};
            3'h2:    return row_bits[7:0];
            3'h3:    return row_bits[15:8];
            default: return {7'h00, row_bits[16]};
        endcase
    endfunction

endpackage

// *** hw/nfc_timer.sv ***
// Down-counting cycle timer for strobe and gap timing
`timescale 1ns/1ps
`default_nettype none
module nfc_timer
    import nfc_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_core_n,
    // Control
    input  wire logic             load,
    input  wire logic [TMR_W-1:0] value,
    output logic                  expired
);
    logic [TMR_W-1:0] cnt;
    logic [TMR_W-1:0] next_cnt;

    always_comb begin
        if (load) begin
            next_cnt = value;
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end else begin
            next_cnt = cnt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign expired = (cnt == TMR_W'(1));
endmodule
`default_nettype wire

// *** tb/nfc_dev_model.sv ***
// Behavioural flash device model facing the host sequencer
`timescale 1ns/1ps
`default_nettype none
module nfc_dev_model
    import nfc_pkg::*;
#(
    parameter int BUSY_NS = 400
)
(
    // Pins
    input  wire nfc_pins_t  pins,
    input  wire logic       hold_busy,
    output logic [7:0]      io_in,
    output logic            rb_low
);
    logic [7:0]  cmd = 8'h00;
    logic [7:0]  abyte [5];
    logic [7:0]  dout = 8'h00;
    logic [7:0]  din = 8'h00;
    logic [11:0] col = 12'h000;
    logic        busy = 1'b0;
    int          idx = 0;
    wire         sel = !pins.chip_select_n;
    wire         oc = sel && !pins.command_latch_strobe && !pins.address_latch_strobe;
    assign rb_low = busy | hold_busy;
    assign io_in = pins.io_oe ? pins.io_out : (oc && !pins.output_strobe_n) ? dout : ~dout;
    always @(posedge pins.write_strobe_n) begin
        if (sel && pins.command_latch_strobe && !pins.address_latch_strobe
            && (!rb_low || pins.io_out inside {8'h70, 8'h71, 8'hff})) begin
            cmd = pins.io_out;
            idx = 0;
            if (cmd == 8'h30) col = {abyte[1][3:0], abyte[0]};
            if (cmd inside {8'h30, 8'h31, 8'h3f, 8'h3a}) busy = 1'b1;
            if (pins.protect_n && cmd inside {8'h10, 8'h15, 8'h11, 8'hd0}) busy = 1'b1;
        end else if (sel && pins.address_latch_strobe && !pins.command_latch_strobe && idx < 5) begin
            abyte[idx] = pins.io_out;
            idx++;
        end else if (sel && !pins.command_latch_strobe && !pins.address_latch_strobe) begin
            din = pins.io_out;
        end
    end
    always @(negedge pins.output_strobe_n) begin
        if (oc) begin
            dout = (cmd inside {8'h70, 8'h71}) ? {1'b0, !rb_low, 6'h00} : col[7:0];
            col = col + 12'h001;
        end
    end
    always @(posedge busy) begin
        #(BUSY_NS);
        busy = 1'b0;
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the flash host sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_top
    import nfc_pkg::*;
;
    typedef struct packed {
        nfc_kind_t kind; logic [7:0] data; logic [11:0] col; logic [16:0] row;
        logic refused; logic [7:0] rd; logic ap; logic hb;
    } nfc_row_t;
    localparam nfc_row_t ROWS [17] = '{
        '{K_CMD, 8'h70, 12'h000, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b0},
        '{K_READ, 8'h00, 12'h000, 17'h00000, 1'b0, 8'h40, 1'b1, 1'b0},
        '{K_ADDR, 8'h00, 12'h7fe, 17'h10041, 1'b0, 8'h00, 1'b1, 1'b0},
        '{K_CMD, 8'h30, 12'h000, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b0},
        '{K_READ, 8'h00, 12'h000, 17'h00000, 1'b0, 8'hfe, 1'b1, 1'b0},
        '{K_READ, 8'h00, 12'h000, 17'h00000, 1'b0, 8'hff, 1'b1, 1'b0},
        '{K_WRITE, 8'ha5, 12'h000, 17'h00000, 1'b1, 8'h00, 1'b0, 1'b0},
        '{K_CMD, 8'h80, 12'h000, 17'h00000, 1'b1, 8'h00, 1'b1, 1'b1},
        '{K_CMD, 8'h70, 12'h000, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b1},
        '{K_READ, 8'h00, 12'h000, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b1},
        '{K_CMD, 8'h81, 12'h000, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b0},
        '{K_CMD, 8'h15, 12'h000, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b0},
        '{K_CMD, 8'h80, 12'h000, 17'h00000, 1'b1, 8'h00, 1'b1, 1'b0},
        '{K_CMD, 8'hff, 12'h000, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b0},
        '{K_CMD, 8'h80, 12'h000, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b0},
        '{K_COL, 8'h00, 12'h7fe, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b0},
        '{K_WRITE, 8'h5a, 12'h000, 17'h00000, 1'b0, 8'h00, 1'b1, 1'b0}};
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       req_valid = 1'b0;
    nfc_req_t   req = '0;
    logic       allow_program = 1'b1;
    logic       hold_busy = 1'b0;
    logic       req_ready;
    nfc_rsp_t   rsp;
    nfc_pins_t  pins;
    logic [7:0] io_in;
    logic       rb_low;
    int         miscompares = 0;
    int         compares = 0;
    always #4 core_clk = ~core_clk;
    nfc_host nfc_host_i (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp(rsp), .allow_program(allow_program), .pins(pins),
        .io_in(io_in), .ready_busy_n(!rb_low));
    nfc_dev_model nfc_dev_model_i (.pins(pins), .hold_busy(hold_busy), .io_in(io_in),
        .rb_low(rb_low));
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic run_row(input nfc_row_t r);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        allow_program = r.ap;
        hold_busy = r.hb;
        @(posedge core_clk);
        #1;
        req = '{r.kind, r.data, r.col, r.row[16:6], r.row[5:0]};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        while (rsp.done !== 1'b1 && rsp.refused !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 3000) miscompares++;
        `CHK(rsp.refused, r.refused)
        if (r.kind == K_READ) `CHK(rsp.rd_data, r.rd)
    endtask
    initial begin
        #400000;
        miscompares++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        `CHK(pins.protect_n, 1'b0)
        rst_n = 1'b1;
        foreach (ROWS[i]) run_row(ROWS[i]);
        foreach (nfc_dev_model_i.abyte[k])
            `CHK(nfc_dev_model_i.abyte[k], k == 0 ? 8'hfe : k == 1 ? 8'h07 : k == 2 ? 8'h41 : {7'h00, k == 4})
        `CHK(nfc_dev_model_i.din, 8'h5a)
        rst_n = 1'b0;
        @(posedge core_clk);
        #1;
        `CHK({pins.chip_select_n, pins.io_oe, req_ready}, 3'h4)
        rst_n = 1'b1;
        run_row(ROWS[0]);
        stop_test();
    end
endmodule
`default_nettype wire
